// ===== pd_phy_pkg.sv
// Purpose: shared constants and types for the pd baseband phy and attach logic
// Assumes: 200 MHz core clock
// Notes: overview of behaviour follows
// Overview of operation
// RULE1: every bit starts with a line transition
// RULE2: a one adds a mid-bit transition
// RULE3: preamble starts by driving line low
// RULE4: far receiver tolerates lost first edge
// RULE5: closing edge after last packet bit
// RULE6: drive only while sending, else release
// RULE7: use only the attach-selected pin
// RULE8: one driver on wire at once
// RULE9: transmit peak level is software programmable
// RULE10: identical detection logic per pin
// RULE11: unattached: watch both, power off
// RULE12: rd on a, open b: vbus
// RULE13: rd on b, open a: vbus
// RULE14: ra on a: await sink, power off
// RULE15: ra on b: await sink, power off
// RULE16: ra a, rd b: vbus, vconn a
// RULE17: rd a, ra b: vbus, vconn b
// RULE18: rd-rd debug, ra-ra audio accessory
// RULE19: detach when pin above detach threshold
// RULE20: bit timing from programmable clock divider
// RULE21: status value with clearable change flag
package pd_phy_pkg;
  localparam int CLK_MHZ = 200;
  localparam int DEBOUNCE_US = 10;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
  localparam int DIV_W = 12;
  localparam logic [DIV_W-1:0] DIV_RESET = 12'h0C8;
  localparam int PEAK_W = 4;
  localparam logic [PEAK_W-1:0] PEAK_RESET = 4'h8;
  localparam int BYTE_W = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // analog comparator result per pin
  typedef enum logic [1:0] {
    TERM_OPEN,
    TERM_RD,
    TERM_RA
  } term_type;

  typedef enum logic [3:0] {
    ATT_NONE,
    ATT_SINK_A,
    ATT_SINK_B,
    ATT_CABLE_A,
    ATT_CABLE_B,
    ATT_CABLE_A_SINK_B,
    ATT_SINK_A_CABLE_B,
    ATT_DEBUG,
    ATT_AUDIO
  } attach_type;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_LEAD,
    TX_DATA,
    TX_CLOSE
  } tx_state_type;
endpackage

// ===== pd_bmc_phy.sv
// Purpose: bmc transmit/receive and dfp attach classifier for two cc pins
// Assumes: pin comparator outputs are asynchronous and synchronised here
// Notes: analog levels are only carried as settings to the driver
`timescale 1ns/1ps
`default_nettype none
module pd_bmc_phy #(
  parameter int DEBOUNCE = pd_phy_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [pd_phy_pkg::DIV_W-1:0] half_bit_div_in,
  input wire logic [pd_phy_pkg::PEAK_W-1:0] tx_peak_level_in,
  input wire logic tx_start_in,
  input wire logic [pd_phy_pkg::BYTE_W-1:0] tx_data_in,
  input wire logic tx_last_in,
  input wire logic [1:0] config_channel_pin_a_term_in,
  input wire logic [1:0] config_channel_pin_b_term_in,
  input wire logic config_channel_pin_a_in,
  input wire logic config_channel_pin_b_in,
  input wire logic status_clear_in,
  output logic tx_ready_out,
  output logic tx_busy_out,
  output logic [pd_phy_pkg::PEAK_W-1:0] tx_peak_level_out,
  output logic config_channel_pin_a_out,
  output logic config_channel_pin_a_oe_out,
  output logic config_channel_pin_b_out,
  output logic config_channel_pin_b_oe_out,
  output logic rx_bit_valid_out,
  output logic rx_bit_out,
  output logic vbus_enable_out,
  output logic vconn_a_out,
  output logic vconn_b_out,
  output logic [3:0] attach_status_out,
  output logic attach_change_out
);
  import pd_phy_pkg::*;

  // ----------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  logic [5:0] sync1;
  logic [5:0] sync2;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else begin
      sync1 <= {config_channel_pin_b_term_in, config_channel_pin_a_term_in,
                config_channel_pin_b_in, config_channel_pin_a_in};
      sync2 <= sync1;
    end
  end

  function automatic term_type to_term(input logic [1:0] raw);
    case (raw)
      2'h1: to_term = TERM_RD;
      2'h2: to_term = TERM_RA;
      default: to_term = TERM_OPEN;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // per-pin termination debounce
  // ----------------------------------------------------------------
  term_type pin_term [2];
  // RULE10: identical pin detectors
  for (genvar p = 0; p < 2; p++) begin : g_pin
    logic [15:0] cnt;
    term_type seen;
    term_type stable;
    always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
        cnt <= 16'h0000;
        seen <= TERM_OPEN;
        stable <= TERM_OPEN;
      end else if (to_term(sync2[2+2*p +: 2]) != seen) begin
        seen <= to_term(sync2[2+2*p +: 2]);
        cnt <= 16'h0000;
      end else if (cnt >= 16'(DEBOUNCE - 1)) begin
        stable <= seen;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
    assign pin_term[p] = stable;
  end

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    tx_state_type tx_state;
    logic [DIV_W-1:0] div_cnt;
    logic [BYTE_W-1:0] shreg;
    logic [2:0] bit_idx;
    logic half;
    logic last;
    logic level;
    logic tx_ready;
    logic tx_busy;
    logic [PEAK_W-1:0] peak;
    logic drv_a;
    logic drv_b;
    logic oe_a;
    logic oe_b;
    logic rx_prev;
    logic [DIV_W+1:0] rx_cnt;
    logic rx_half_seen;
    logic rx_valid;
    logic rx_bit;
    attach_type att;
    logic vbus;
    logic vconn_a;
    logic vconn_b;
    logic change;
  } state_type;

  state_type r;
  state_type next_r;

  logic div_tick;
  logic rx_pin;
  logic use_b;
  logic [DIV_W+1:0] full_lim;
  logic [DIV_W+1:0] thr;

  always_comb begin
    next_r = r;
    next_r.rx_valid = 1'b0;
    // RULE20: half-bit divider tick
    div_tick = (r.div_cnt == '0);
    // RULE7: pin chosen by attach orientation
    use_b = (r.att == ATT_SINK_B) || (r.att == ATT_CABLE_A_SINK_B);
    rx_pin = use_b ? sync2[1] : sync2[0];
    full_lim = {2'b00, half_bit_div_in} << 1;
    thr = ({2'b00, half_bit_div_in} * 14'h0003) >> 1;

    // RULE9: programmable peak setting
    next_r.peak = tx_peak_level_in;

    // ---------------- transmitter ----------------
    if (r.tx_state != TX_IDLE) begin
      next_r.div_cnt = div_tick ? half_bit_div_in : r.div_cnt - 1'b1;
    end
    case (r.tx_state)
      TX_IDLE: begin
        next_r.tx_busy = 1'b0;
        next_r.tx_ready = 1'b0;
        if (tx_start_in) begin
          next_r.tx_state = TX_LEAD;
          next_r.shreg = tx_data_in;
          next_r.last = tx_last_in;
          next_r.bit_idx = 3'h0;
          next_r.half = 1'b0;
          next_r.div_cnt = half_bit_div_in;
          // RULE3: start preamble at low level
          next_r.level = 1'b0;
          next_r.tx_busy = 1'b1;
        end
      end
      TX_LEAD: begin
        if (div_tick) begin
          next_r.tx_state = TX_DATA;
          // RULE1: edge at bit start
          next_r.level = ~r.level;
        end
      end
      TX_DATA: begin
        if (div_tick) begin
          if (!r.half) begin
            next_r.half = 1'b1;
            // RULE2: mid-bit edge for a one
            if (r.shreg[0]) begin
              next_r.level = ~r.level;
            end
            if (r.bit_idx == BIT_LAST) begin
              next_r.tx_ready = !r.last;
            end
          end else begin
            next_r.half = 1'b0;
            next_r.level = ~r.level;
            next_r.tx_ready = 1'b0;
            if (r.bit_idx == BIT_LAST) begin
              if (r.last) begin
                next_r.tx_state = TX_CLOSE;
              end else if (tx_start_in) begin
                next_r.shreg = tx_data_in;
                next_r.last = tx_last_in;
                next_r.bit_idx = 3'h0;
              end else begin
                // underrun: end with closing edge already made
                next_r.tx_state = TX_CLOSE;
              end
            end else begin
              next_r.shreg = r.shreg >> 1;
              next_r.bit_idx = r.bit_idx + 3'h1;
            end
          end
        end
      end
      TX_CLOSE: begin
        // RULE5: closing edge was driven, hold one half bit
        if (div_tick) begin
          next_r.tx_state = TX_IDLE;
          next_r.tx_busy = 1'b0;
        end
      end
      default: next_r.tx_state = TX_IDLE;
    endcase

    // RULE6: drive only while a packet is in flight
    // RULE8: never drive both pins, released when idle
    next_r.oe_a = (next_r.tx_state != TX_IDLE) && !use_b;
    next_r.oe_b = (next_r.tx_state != TX_IDLE) && use_b;
    next_r.drv_a = next_r.oe_a & next_r.level;
    next_r.drv_b = next_r.oe_b & next_r.level;

    // ---------------- receiver ----------------
    next_r.rx_prev = rx_pin;
    if (r.tx_busy || r.att == ATT_NONE) begin
      next_r.rx_cnt = '0;
      next_r.rx_half_seen = 1'b0;
    end else if (rx_pin != r.rx_prev) begin
      // RULE20: interval against 1.5 half-bits
      // RULE4: first edge only starts timing
      next_r.rx_cnt = '0;
      if (r.rx_cnt >= thr) begin
        next_r.rx_valid = (r.rx_cnt <= full_lim + full_lim);
        next_r.rx_bit = 1'b0;
        next_r.rx_half_seen = 1'b0;
      end else if (r.rx_half_seen) begin
        next_r.rx_valid = 1'b1;
        next_r.rx_bit = 1'b1;
        next_r.rx_half_seen = 1'b0;
      end else begin
        next_r.rx_half_seen = 1'b1;
      end
    end else if (r.rx_cnt != '1) begin
      next_r.rx_cnt = r.rx_cnt + 1'b1;
    end

    // ---------------- attach classifier ----------------
    case (r.att)
      // RULE11: watch both pins, power off
      ATT_NONE: begin
        if (pin_term[0] == TERM_RD && pin_term[1] == TERM_RD) begin
          // RULE18: debug accessory
          next_r.att = ATT_DEBUG;
        end else if (pin_term[0] == TERM_RA && pin_term[1] == TERM_RA) begin
          next_r.att = ATT_AUDIO;
        end else if (pin_term[0] == TERM_RA && pin_term[1] == TERM_RD) begin
          next_r.att = ATT_CABLE_A_SINK_B;
        end else if (pin_term[0] == TERM_RD && pin_term[1] == TERM_RA) begin
          next_r.att = ATT_SINK_A_CABLE_B;
        end else if (pin_term[0] == TERM_RD) begin
          next_r.att = ATT_SINK_A;
        end else if (pin_term[1] == TERM_RD) begin
          next_r.att = ATT_SINK_B;
        end else if (pin_term[0] == TERM_RA) begin
          next_r.att = ATT_CABLE_A;
        end else if (pin_term[1] == TERM_RA) begin
          next_r.att = ATT_CABLE_B;
        end
      end
      // RULE12: watch pin a only
      // RULE19: open pin means above detach threshold
      ATT_SINK_A: if (pin_term[0] == TERM_OPEN) next_r.att = ATT_NONE;
      // RULE13: watch pin b only
      ATT_SINK_B: if (pin_term[1] == TERM_OPEN) next_r.att = ATT_NONE;
      // RULE14: sink on b, detach on a
      ATT_CABLE_A: begin
        if (pin_term[0] == TERM_OPEN) begin
          next_r.att = ATT_NONE;
        end else if (pin_term[1] == TERM_RD) begin
          next_r.att = ATT_CABLE_A_SINK_B;
        end
      end
      // RULE15: sink on a, detach on b
      ATT_CABLE_B: begin
        if (pin_term[1] == TERM_OPEN) begin
          next_r.att = ATT_NONE;
        end else if (pin_term[0] == TERM_RD) begin
          next_r.att = ATT_SINK_A_CABLE_B;
        end
      end
      // RULE16: pin a ignored for detach
      ATT_CABLE_A_SINK_B: if (pin_term[1] == TERM_OPEN) next_r.att = ATT_NONE;
      // RULE17: pin b ignored for detach
      ATT_SINK_A_CABLE_B: if (pin_term[0] == TERM_OPEN) next_r.att = ATT_NONE;
      // RULE18: either pin may signal detach
      ATT_DEBUG, ATT_AUDIO: begin
        if (pin_term[0] == TERM_OPEN || pin_term[1] == TERM_OPEN) begin
          next_r.att = ATT_NONE;
        end
      end
      default: next_r.att = ATT_NONE;
    endcase

    next_r.vbus = (next_r.att == ATT_SINK_A) || (next_r.att == ATT_SINK_B) ||
                  (next_r.att == ATT_CABLE_A_SINK_B) ||
                  (next_r.att == ATT_SINK_A_CABLE_B);
    next_r.vconn_a = (next_r.att == ATT_CABLE_A_SINK_B);
    next_r.vconn_b = (next_r.att == ATT_SINK_A_CABLE_B);

    // RULE21: change flag, set beats clear
    if (next_r.att != r.att) begin
      next_r.change = 1'b1;
    end else if (status_clear_in) begin
      next_r.change = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.tx_state <= TX_IDLE;
      r.att <= ATT_NONE;
      r.peak <= PEAK_RESET;
      r.div_cnt <= DIV_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign tx_ready_out = r.tx_ready;
  assign tx_busy_out = r.tx_busy;
  assign tx_peak_level_out = r.peak;
  assign config_channel_pin_a_out = r.drv_a;
  assign config_channel_pin_a_oe_out = r.oe_a;
  assign config_channel_pin_b_out = r.drv_b;
  assign config_channel_pin_b_oe_out = r.oe_b;
  assign rx_bit_valid_out = r.rx_valid;
  assign rx_bit_out = r.rx_bit;
  assign vbus_enable_out = r.vbus;
  assign vconn_a_out = r.vconn_a;
  assign vconn_b_out = r.vconn_b;
  assign attach_status_out = r.att;
  assign attach_change_out = r.change;
endmodule
`default_nettype wire

// ===== pd_phy_props.sv
// Purpose: port checks for pd_bmc_phy
// Assumes: half_bit_div_in is held while a packet is on the wire
// Notes: edge spacing is counted in helper logic, not by repetition
`timescale 1ns/1ps
`default_nettype none
module pd_phy_props (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [pd_phy_pkg::DIV_W-1:0] half_bit_div_in,
  input wire logic [pd_phy_pkg::PEAK_W-1:0] tx_peak_level_in,
  input wire logic [pd_phy_pkg::PEAK_W-1:0] tx_peak_level_out,
  input wire logic tx_busy_out,
  input wire logic config_channel_pin_a_out,
  input wire logic config_channel_pin_a_oe_out,
  input wire logic config_channel_pin_b_out,
  input wire logic config_channel_pin_b_oe_out,
  input wire logic rx_bit_valid_out,
  input wire logic vbus_enable_out,
  input wire logic vconn_a_out,
  input wire logic vconn_b_out,
  input wire logic [3:0] attach_status_out,
  input wire logic attach_change_out
);
  import pd_phy_pkg::*;
  logic oe;
  logic drv;
  logic prev;
  logic [DIV_W:0] cnt;
  logic [DIV_W:0] h;
  logic [3:0] st;
  assign oe = config_channel_pin_a_oe_out | config_channel_pin_b_oe_out;
  assign drv = config_channel_pin_b_oe_out ? config_channel_pin_b_out
    : config_channel_pin_a_out;
  assign h = {1'b0, half_bit_div_in};
  assign st = attach_status_out;
  // --------------------------------
  // edge spacing counter
  // --------------------------------
  // all ones while idle, so the lead-low span lands on the same figure
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt <= '1;
      prev <= 1'b0;
    end else begin
      prev <= drv;
      if (!oe) begin
        cnt <= '1;
      end else if (drv != prev) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + 13'h1;
      end
    end
  end
  // --------------------------------
  // properties
  // --------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  a_drive_busy: assert property (oe |-> tx_busy_out)
    else $error("pin driven outside a packet");
  a_single_driver: assert property (!(config_channel_pin_a_oe_out &&
    config_channel_pin_b_oe_out)) else $error("both pins driven");
  a_pin_select: assert property (oe |->
    config_channel_pin_b_oe_out == (st == 4'h2 || st == 4'h5))
    else $error("wrong pin driven");
  a_lead_low: assert property ($rose(oe) |-> !drv)
    else $error("packet not opened low");
  a_bit_spacing: assert property (oe && $past(oe) &&
    drv != $past(drv) |-> cnt == h || cnt == {h[DIV_W-1:0], 1'b1})
    else $error("edge spacing off");
  a_close_edge: assert property ($fell(oe) |-> cnt == h)
    else $error("release not one half bit after last edge");
  a_power_off: assert property ($stable(st) &&
    (st == 4'h0 || st == 4'h3 || st == 4'h4) |-> !(vbus_enable_out |
    vconn_a_out | vconn_b_out)) else $error("power on without sink");
  a_vbus_sink: assert property ($stable(st) && (st == 4'h1 ||
    st == 4'h2 || st == 4'h5 || st == 4'h6) |-> vbus_enable_out)
    else $error("vbus off with sink");
  a_vconn_pin: assert property ($stable(st) && st < 4'h7 |->
    vconn_a_out == (st == 4'h5) && vconn_b_out == (st == 4'h6))
    else $error("vconn on wrong pin");
  a_change_set: assert property ($changed(st) |-> ##[0:1]
    attach_change_out) else $error("change flag not set");
  a_peak_copy: assert property ($stable(tx_peak_level_in)[*2] |->
    tx_peak_level_out == tx_peak_level_in) else $error("peak not copied");
  c_cable_sink: cover property (st == 4'h5);
  c_packet_end: cover property ($fell(oe));
  c_rx_bit: cover property (rx_bit_valid_out);
endmodule
bind pd_bmc_phy pd_phy_props u_props (.clk_in, .resetn_in,
  .half_bit_div_in, .tx_peak_level_in, .tx_peak_level_out, .tx_busy_out,
  .config_channel_pin_a_out, .config_channel_pin_a_oe_out,
  .config_channel_pin_b_out, .config_channel_pin_b_oe_out,
  .rx_bit_valid_out, .vbus_enable_out, .vconn_a_out, .vconn_b_out,
  .attach_status_out, .attach_change_out);
`default_nettype wire

// ===== pd_far_port.sv
// Purpose: far pd port sending one bmc frame on the cc wire
// Assumes: same half bit setting as the device
// Notes: released wire shows the dc bias, resolved in the bench
`timescale 1ns/1ps
`default_nettype none
module pd_far_port (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [11:0] half_in,
  input wire logic [15:0] word_in,
  output logic line_out,
  output logic oe_out
);
  initial begin
    line_out = 1'b0;
    oe_out = 1'b0;
  end
  task automatic half_wait;
    repeat (half_in + 1) @(posedge clk_in);
    #1;
  endtask
  always @(posedge go_in) begin : frame
    int i;
    // take the wire only for the frame
    oe_out = 1'b1;
    line_out = 1'b0;
    half_wait();
    for (i = 0; i < 16; i++) begin
      line_out = ~line_out;
      half_wait();
      if (word_in[i[3:0]]) line_out = ~line_out;
      half_wait();
    end
    line_out = ~line_out;
    half_wait();
    oe_out = 1'b0;
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: self-checking bench for pd_bmc_phy
// Assumes: short debounce and half bit of five cycles
// Notes: undriven wire rests at the dc bias level
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pd_phy_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [DIV_W-1:0] half = 12'h004;
  logic [PEAK_W-1:0] peak = 4'h8;
  logic [PEAK_W-1:0] peak_o;
  logic start = 1'b0;
  logic last = 1'b0;
  logic clr = 1'b0;
  logic far_go = 1'b0;
  logic [7:0] data = 8'h00;
  logic [1:0] ta = 2'h0;
  logic [1:0] tb = 2'h0;
  logic [3:0] st;
  logic far_line, far_oe, ready, busy, pa, pa_oe, pb, pb_oe, rxv, rxb;
  logic vbus, vca, vcb, chg, wa, wb, oe, drv, prev_drv, prev_oe;
  logic [7:0] rx_sr = 8'h00;
  int ntog = 0;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [11:0] rows [9] = '{12'h000, 12'h414, 12'h124, 12'h830, 12'h240,
    12'h956, 12'h665, 12'h570, 12'hA80};
  always #2.5 clk_in = ~clk_in;
  assign wa = pa_oe ? pa : (far_oe ? far_line : 1'b1);
  assign wb = pb_oe ? pb : 1'b1;
  assign oe = pa_oe | pb_oe;
  assign drv = pb_oe ? pb : pa;
  pd_bmc_phy #(.DEBOUNCE(4)) dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .half_bit_div_in(half), .tx_peak_level_in(peak), .tx_start_in(start),
    .tx_data_in(data), .tx_last_in(last),
    .config_channel_pin_a_term_in(ta), .config_channel_pin_b_term_in(tb),
    .config_channel_pin_a_in(wa), .config_channel_pin_b_in(wb),
    .status_clear_in(clr), .tx_ready_out(ready), .tx_busy_out(busy),
    .tx_peak_level_out(peak_o), .config_channel_pin_a_out(pa),
    .config_channel_pin_a_oe_out(pa_oe), .config_channel_pin_b_out(pb),
    .config_channel_pin_b_oe_out(pb_oe), .rx_bit_valid_out(rxv),
    .rx_bit_out(rxb), .vbus_enable_out(vbus), .vconn_a_out(vca),
    .vconn_b_out(vcb), .attach_status_out(st), .attach_change_out(chg));
  pd_far_port far (.clk_in(clk_in), .go_in(far_go), .half_in(half),
    .word_in(16'hC355), .line_out(far_line), .oe_out(far_oe));
  // --------------------------------
  // wire monitor
  // --------------------------------
  always @(posedge clk_in) begin
    prev_drv <= drv;
    prev_oe <= oe;
    if (oe && prev_oe && drv !== prev_drv) ntog <= ntog + 1;
    if (rxv === 1'b1) rx_sr <= {rxb, rx_sr[7:1]};
  end
  // --------------------------------
  // tasks
  // --------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // a wait that runs out ends the run as failed
  task automatic wait_sig(input int w, input logic lvl);
    int i;
    for (i = 0; i < 400; i++) begin
      if ((w == 0 ? ready : busy) === lvl) return;
      step(1);
    end
    n_mismatch++;
    print_verdict();
  endtask
  task automatic set_terms(input logic [1:0] a, input logic [1:0] b);
    ta = a;
    tb = b;
    step(20);
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin : main
    int r;
    int n0;
    step(6);
    check(16'(peak_o), 16'h0008);
    check(16'({oe, vbus, vca, vcb, busy, chg, st}), 16'h0000);
    step(6);
    resetn_in = 1'b1;
    step(6);
    peak = 4'h3;
    step(3);
    check(16'(peak_o), 16'h0003);
    for (r = 0; r < 9; r++) begin
      set_terms(2'h0, 2'h0);
      check(16'(st), 16'h0000);
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      step(1);
      check(16'(chg), 16'h0000);
      set_terms(rows[r][11:10], rows[r][9:8]);
      check(16'(st), 16'(rows[r][7:4]));
      if (r < 7) check(16'({vbus, vca, vcb}), 16'(rows[r][2:0]));
      check(16'(chg), 16'(r != 0));
    end
    set_terms(2'h0, 2'h0);
    set_terms(2'h2, 2'h0);
    set_terms(2'h2, 2'h1);
    check(16'({st, vbus, vca, vcb}), 16'h002E);
    for (r = 0; r < 2; r++) begin
      set_terms(2'h0, 2'h0);
      set_terms(r == 0 ? 2'h1 : 2'h0, r == 0 ? 2'h0 : 2'h1);
      n0 = ntog;
      data = 8'hA5;
      start = 1'b1;
      step(1);
      start = 1'b0;
      wait_sig(0, 1'b1);
      data = 8'h3C;
      last = 1'b1;
      start = 1'b1;
      wait_sig(0, 1'b0);
      start = 1'b0;
      last = 1'b0;
      wait_sig(1, 1'b0);
      check(16'(ntog - n0), 16'h0019);
    end
    set_terms(2'h0, 2'h0);
    set_terms(2'h1, 2'h0);
    far_go = 1'b1;
    step(1);
    far_go = 1'b0;
    step(200);
    check(16'(rx_sr), 16'h00C3);
    print_verdict();
  end
endmodule
`default_nettype wire
